// file: verilog/data_register_file.sv
/*
 Data, address and stack-pointer register file with sized operand access,
 bit-field extract and insert with wrap, quad-word and decimal digit ports.
 Assumes the execution datapath never writes the same register through two
 write ports in one cycle; the field port then wins over the sized port.
*/
`timescale 1ns/10ps
module data_register_file
    import regfile_pkg::*;
(
    input  wire logic                           clk_sys,
    input  wire logic                           rst_n,
    input  wire regfile_pkg::data_wr_t          data_wr,
    input  wire regfile_pkg::quad_wr_t          quad_wr,
    input  wire regfile_pkg::field_wr_t         field_wr,
    input  wire regfile_pkg::addr_wr_t          addr_wr,
    input  wire logic [regfile_pkg::DSEL_W-1:0] rd_sel,
    input  wire regfile_pkg::op_size_t          rd_size,
    input  wire logic [regfile_pkg::DSEL_W-1:0] qrd_hi_sel,
    input  wire logic [regfile_pkg::DSEL_W-1:0] qrd_lo_sel,
    input  wire logic [regfile_pkg::DSEL_W-1:0] frd_sel,
    input  wire logic [regfile_pkg::OFS_W-1:0]  frd_offset,
    input  wire logic [regfile_pkg::WID_W-1:0]  frd_width,
    input  wire logic [regfile_pkg::DSEL_W-1:0] digit_sel,
    input  wire logic [1:0]                     digit_idx,
    input  wire logic [regfile_pkg::ASEL_W-1:0] ard_sel,
    input  wire logic                           ard_is_word,
    output logic      [regfile_pkg::DATA_W-1:0] rd_data,
    output logic      [2*regfile_pkg::DATA_W-1:0] qrd_data,
    output logic      [regfile_pkg::DATA_W-1:0] frd_data,
    output logic      [regfile_pkg::DIGIT_W-1:0] digit_data,
    output logic      [regfile_pkg::DATA_W-1:0] ard_data
);
    logic [DATA_W-1:0]      dreg [NUM_DATA];
    logic [LANES-1:0]       dlane [NUM_DATA];
    logic [DATA_W-1:0]      dwdata [NUM_DATA];
    logic [DATA_W-1:0]      areg_q [NUM_AREG];
    logic [DATA_W-1:0]      areg_d [NUM_AREG];
    logic [DATA_W-1:0]      rd_data_d;
    logic [2*DATA_W-1:0]    qrd_data_d;
    logic [DATA_W-1:0]      frd_data_d;
    logic [DIGIT_W-1:0]     digit_d;
    logic [DATA_W-1:0]      ard_data_d;
    logic [LANES-1:0]       size_lanes;
    logic [DATA_W-1:0]      fmask;
    logic [DATA_W-1:0]      fins;
    logic [DATA_W-1:0]      rd_data_q;
    logic [2*DATA_W-1:0]    qrd_data_q;
    logic [DATA_W-1:0]      frd_data_q;
    logic [DIGIT_W-1:0]     digit_q;
    logic [DATA_W-1:0]      ard_data_q;

    // Big-endian field mask, offset 0 at bit 31, wrapping past bit 0
    function automatic logic [DATA_W-1:0] field_mask(
        input logic [OFS_W-1:0] ofs,
        input logic [WID_W-1:0] wid
    );
        logic [DATA_W-1:0] m;
        logic [OFS_W-1:0]  pos;
        m = '0;
        for (int i = 0; i < DATA_W; i++)
        begin
            pos = ofs + i[OFS_W-1:0]; // RULE_07
            if (i < int'(wid))
            begin
                m[(DATA_W-1) - int'(pos)] = 1'b1; // RULE_06
            end
        end
        return m;
    endfunction

    // Rotate right so bit 0 of the insert data lands on the field's last bit
    function automatic logic [DATA_W-1:0] rotr(
        input logic [DATA_W-1:0] v,
        input logic [OFS_W-1:0]  n
    );
        return (v >> n) | (v << (6'(DATA_W) - {1'b0, n}));
    endfunction

    function automatic logic [DATA_W-1:0] rotl(
        input logic [DATA_W-1:0] v,
        input logic [OFS_W-1:0]  n
    );
        return (v << n) | (v >> (6'(DATA_W) - {1'b0, n}));
    endfunction

    // Widths 1 to 32; zero is treated as 32
    function automatic logic [WID_W-1:0] fix_width(input logic [WID_W-1:0] w);
        return (w == '0 || w > 6'(DATA_W)) ? 6'(DATA_W) : w;
    endfunction

    // Rotation that puts field LSB at register bit 0: (offset + width) mod 32
    function automatic logic [OFS_W-1:0] align(
        input logic [OFS_W-1:0] ofs,
        input logic [WID_W-1:0] wid
    );
        logic [WID_W-1:0] s;
        s = {1'b0, ofs} + wid;
        return s[OFS_W-1:0];
    endfunction

    always_comb
    begin
        case (data_wr.size)
            SZ_BYTE: size_lanes = LANES_BYTE; // RULE_03
            SZ_WORD: size_lanes = LANES_WORD; // RULE_03
            default: size_lanes = LANES_LONG; // RULE_03
        endcase
    end

    always_comb
    begin
        fmask = field_mask(field_wr.offset, fix_width(field_wr.width));
        fins  = rotr(field_wr.data, align(field_wr.offset, fix_width(field_wr.width)));
    end

    // Write steering per data register
    always_comb
    begin
        for (int r = 0; r < NUM_DATA; r++)
        begin
            dlane[r]  = LANES_NONE;
            dwdata[r] = data_wr.data;
            if (field_wr.en && field_wr.sel == r[DSEL_W-1:0])
            begin
                dlane[r]  = LANES_LONG;
                dwdata[r] = (dreg[r] & ~fmask) | (fins & fmask); // RULE_06
            end
            else if (quad_wr.en && quad_wr.hi_sel == r[DSEL_W-1:0])
            begin
                dlane[r]  = LANES_LONG; // RULE_09
                dwdata[r] = quad_wr.data[2*DATA_W-1:DATA_W];
            end
            else if (quad_wr.en && quad_wr.lo_sel == r[DSEL_W-1:0])
            begin
                dlane[r]  = LANES_LONG; // RULE_09
                dwdata[r] = quad_wr.data[DATA_W-1:0];
            end
            else if (data_wr.en && data_wr.sel == r[DSEL_W-1:0])
            begin
                dlane[r] = size_lanes; // RULE_11
            end
        end
    end

    generate
        for (genvar g = 0; g < NUM_DATA; g++)
        begin : g_dreg
            lane_writer u_reg (
                .clk_sys (clk_sys),
                .rst_n   (rst_n),
                .lane_en (dlane[g]),
                .wr_data (dwdata[g]),
                .value   (dreg[g])
            ); // RULE_01 RULE_02
        end
    endgenerate

    // Address registers and stack pointers; word writes sign-extend
    always_comb
    begin
        for (int r = 0; r < NUM_AREG; r++)
        begin
            areg_d[r] = areg_q[r];
        end
        if (addr_wr.en && int'(addr_wr.sel) < NUM_AREG)
        begin
            if (addr_wr.is_word)
            begin
                areg_d[addr_wr.sel] = {{16{addr_wr.data[15]}}, addr_wr.data[15:0]}; // RULE_08
            end
            else
            begin
                areg_d[addr_wr.sel] = addr_wr.data; // RULE_08
            end
        end
    end

    // Read datapath, registered
    always_comb
    begin
        case (rd_size)
            SZ_BYTE: rd_data_d = {24'h00_0000, dreg[rd_sel][7:0]}; // RULE_04
            SZ_WORD: rd_data_d = {16'h0000, dreg[rd_sel][15:0]}; // RULE_04
            default: rd_data_d = dreg[rd_sel]; // RULE_05
        endcase
        qrd_data_d = {dreg[qrd_hi_sel], dreg[qrd_lo_sel]}; // RULE_09
        frd_data_d = rotl(dreg[frd_sel], align(frd_offset, fix_width(frd_width)))
                   & ~(32'hffff_fffe << (fix_width(frd_width) - 6'h01)); // RULE_07
        digit_d = dreg[digit_sel][8*digit_idx +: DIGIT_W]; // RULE_10
        if (int'(ard_sel) < NUM_AREG)
        begin
            ard_data_d = ard_is_word ? {{16{areg_q[ard_sel][15]}}, areg_q[ard_sel][15:0]}
                                     : areg_q[ard_sel];
        end
        else
        begin
            ard_data_d = REG_RESET;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            for (int r = 0; r < NUM_AREG; r++)
            begin
                areg_q[r] <= REG_RESET;
            end
        end
        else
        begin
            for (int r = 0; r < NUM_AREG; r++)
            begin
                areg_q[r] <= areg_d[r];
            end
        end
    end

    // Read outputs, one cycle behind the selects
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            rd_data_q  <= REG_RESET;
            qrd_data_q <= {REG_RESET, REG_RESET};
            frd_data_q <= REG_RESET;
            digit_q    <= '0;
            ard_data_q <= REG_RESET;
        end
        else
        begin
            rd_data_q  <= rd_data_d;
            qrd_data_q <= qrd_data_d;
            frd_data_q <= frd_data_d;
            digit_q    <= digit_d;
            ard_data_q <= ard_data_d;
        end
    end

    assign rd_data    = rd_data_q;
    assign qrd_data   = qrd_data_q;
    assign frd_data   = frd_data_q;
    assign digit_data = digit_q;
    assign ard_data   = ard_data_q;
endmodule

// file: shared/regfile_pkg.sv
/*
 Constants and carrier types for the data and address register file.
 Assumes a single 20 MHz clock and a synchronous active-low reset.
*/
// Functional notes
// (RULE_01) Eight data registers, all operand sizes
// (RULE_02) Each data register is 32 bits
// (RULE_03) Byte low 8, word low 16, long all
// (RULE_04) Partial access leaves upper bits untouched
// (RULE_05) Long-word bit zero is the LSB
// (RULE_06) Field offset zero is the MSB
// (RULE_07) Field past bit 31 wraps to MSB
// (RULE_08) Seven address registers plus three stack pointers
// (RULE_09) Quad word uses any two data registers
// (RULE_10) Decimal digit in low four bits
// (RULE_11) Sized writes with lane enables, one cycle
package regfile_pkg;
    localparam int DATA_W      = 32;
    localparam int NUM_DATA    = 8;
    localparam int NUM_ADDR    = 7;
    localparam int NUM_SP      = 3;
    localparam int NUM_AREG    = NUM_ADDR + NUM_SP;
    localparam int DSEL_W      = 3;
    localparam int ASEL_W      = 4;
    localparam int OFS_W       = 5;
    localparam int WID_W       = 6;
    localparam int LANES       = 4;
    localparam int DIGIT_W     = 4;
    localparam logic [DATA_W-1:0] REG_RESET = 32'h0000_0000;
    localparam logic [LANES-1:0] LANES_BYTE = 4'h1;
    localparam logic [LANES-1:0] LANES_WORD = 4'h3;
    localparam logic [LANES-1:0] LANES_LONG = 4'hf;
    localparam logic [LANES-1:0] LANES_NONE = 4'h0;

    typedef enum logic [1:0] {
        SZ_BYTE,
        SZ_WORD,
        SZ_LONG
    } op_size_t;

    typedef struct packed {
        logic                   en;
        logic [DSEL_W-1:0]      sel;
        op_size_t               size;
        logic [DATA_W-1:0]      data;
    } data_wr_t;

    typedef struct packed {
        logic                   en;
        logic [DSEL_W-1:0]      hi_sel;
        logic [DSEL_W-1:0]      lo_sel;
        logic [2*DATA_W-1:0]    data;
    } quad_wr_t;

    typedef struct packed {
        logic                   en;
        logic [DSEL_W-1:0]      sel;
        logic [OFS_W-1:0]       offset;
        logic [WID_W-1:0]       width;
        logic [DATA_W-1:0]      data;
    } field_wr_t;

    typedef struct packed {
        logic                   en;
        logic [ASEL_W-1:0]      sel;
        logic                   is_word;
        logic [DATA_W-1:0]      data;
    } addr_wr_t;
endpackage

// file: verilog/lane_writer.sv
/*
 One 32-bit register word with per-byte-lane write enables.
 Assumes the caller decodes the lane mask from the operand size.
*/
`timescale 1ns/10ps
module lane_writer
    import regfile_pkg::*;
(
    input  wire logic                       clk_sys,
    input  wire logic                       rst_n,
    input  wire logic [regfile_pkg::LANES-1:0]  lane_en,
    input  wire logic [regfile_pkg::DATA_W-1:0] wr_data,
    output logic      [regfile_pkg::DATA_W-1:0] value
);
    logic [DATA_W-1:0] value_q;
    logic [DATA_W-1:0] value_d;

    always_comb
    begin
        value_d = value_q;
        for (int l = 0; l < LANES; l++)
        begin
            if (lane_en[l])
            begin
                value_d[l*8 +: 8] = wr_data[l*8 +: 8]; // RULE_04
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            value_q <= REG_RESET;
        end
        else
        begin
            value_q <= value_d;
        end
    end

    assign value = value_q;
endmodule

// file: sim/regfile_props.sv
/*
 Read-port checks for the register file.
 Bound to data_register_file; sees its ports only.
*/
`timescale 1ns/10ps
module regfile_props
    import regfile_pkg::*;
(
    input wire logic                  clk_sys,
    input wire logic                  rst_n,
    input wire regfile_pkg::data_wr_t  data_wr,
    input wire regfile_pkg::quad_wr_t  quad_wr,
    input wire regfile_pkg::field_wr_t field_wr,
    input wire logic [2:0]            rd_sel,
    input wire regfile_pkg::op_size_t  rd_size,
    input wire logic [2:0]            qrd_hi_sel,
    input wire logic [2:0]            qrd_lo_sel,
    input wire logic [2:0]            frd_sel,
    input wire logic [4:0]            frd_offset,
    input wire logic [5:0]            frd_width,
    input wire logic [3:0]            ard_sel,
    input wire logic [31:0]           rd_data,
    input wire logic [63:0]           qrd_data,
    input wire logic [31:0]           frd_data,
    input wire logic [31:0]           ard_data
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence byte_wr_s;
        data_wr.en && data_wr.size == SZ_BYTE && qrd_lo_sel == data_wr.sel;
    endsequence
    sequence quiet_s;
        !data_wr.en && !field_wr.en && !quad_wr.en;
    endsequence
    a_byte_read: assert property (rd_size == SZ_BYTE && rd_sel == qrd_lo_sel
        |=> rd_data == {24'h0, qrd_data[7:0]}) else $error("byte read wrong");
    a_word_read: assert property (rd_size == SZ_WORD && rd_sel == qrd_lo_sel
        |=> rd_data == {16'h0, qrd_data[15:0]}) else $error("word read wrong");
    a_long_read: assert property (rd_size == SZ_LONG && rd_sel == qrd_lo_sel
        |=> rd_data == qrd_data[31:0]) else $error("long read wrong");
    a_field_msb: assert property (frd_width == 6'd1 && frd_sel == qrd_lo_sel
        |=> frd_data == {31'h0, qrd_data[5'd31 - $past(frd_offset)]}) else $error("field bit");
    a_field_wrap: assert property (frd_width == 6'd2 && frd_offset == 5'd31
        && frd_sel == qrd_lo_sel |=> frd_data == {30'h0, qrd_data[0], qrd_data[31]})
        else $error("field wrap wrong");
    a_byte_keep: assert property (byte_wr_s ##1 quiet_s ##0 $stable(qrd_lo_sel)
        |=> qrd_data[31:8] == $past(qrd_data[31:8])
        && qrd_data[7:0] == $past(data_wr.data[7:0], 2)) else $error("byte write wrong");
    a_quad_pair: assert property (quad_wr.en && quad_wr.hi_sel != quad_wr.lo_sel
        ##1 quiet_s ##0 (qrd_hi_sel == $past(quad_wr.hi_sel)
        && qrd_lo_sel == $past(quad_wr.lo_sel)) |=> qrd_data == $past(quad_wr.data, 2))
        else $error("quad write wrong");
    a_addr_unmapped: assert property (ard_sel >= 4'ha |=> ard_data == 32'h0)
        else $error("unmapped address read");
endmodule

// file: sim/exec_datapath.sv
/*
 Execution datapath model driving the register file write ports.
 Assumes its tasks are entered at a falling clock edge.
*/
`timescale 1ns/10ps
module exec_datapath
    import regfile_pkg::*;
(
    input  wire logic                   clk_sys,
    output regfile_pkg::data_wr_t        data_wr = '0,
    output regfile_pkg::quad_wr_t        quad_wr = '0,
    output regfile_pkg::field_wr_t       field_wr = '0,
    output regfile_pkg::addr_wr_t        addr_wr = '0
);
    task automatic put_data(input logic [2:0] s, input op_size_t z, input logic [31:0] d);
        @(negedge clk_sys);
        data_wr = '{1'b1, s, z, d};
        @(negedge clk_sys);
        data_wr = '{1'b0, ~s, z, ~d};
    endtask
    task automatic put_quad(input logic [2:0] h, input logic [2:0] l, input logic [63:0] d);
        @(negedge clk_sys);
        quad_wr = '{1'b1, h, l, d};
        @(negedge clk_sys);
        quad_wr = '{1'b0, ~h, ~l, ~d};
    endtask
    task automatic put_field(input logic [2:0] s, input logic [4:0] o, input logic [5:0] w,
                             input logic [31:0] d);
        @(negedge clk_sys);
        field_wr = '{1'b1, s, o, w, d};
        @(negedge clk_sys);
        field_wr = '{1'b0, ~s, ~o, w, ~d};
    endtask
    task automatic put_addr(input logic [3:0] s, input logic w, input logic [31:0] d);
        @(negedge clk_sys);
        addr_wr = '{1'b1, s, w, d};
        @(negedge clk_sys);
        addr_wr = '{1'b0, ~s, w, ~d};
    endtask
endmodule

// file: sim/tb.sv
/*
 Self-checking bench for the register file.
 Assumes exec_datapath drives the write ports.
*/
`timescale 1ns/10ps
module tb;
    import regfile_pkg::*;
    logic             clk_sys;
    logic             rst_n;
    data_wr_t         data_wr;
    quad_wr_t         quad_wr;
    field_wr_t        field_wr;
    addr_wr_t         addr_wr;
    logic [2:0]       rd_sel, qrd_hi_sel, qrd_lo_sel, frd_sel, digit_sel;
    op_size_t         rd_size;
    logic [4:0]       frd_offset;
    logic [5:0]       frd_width;
    logic [1:0]       digit_idx;
    logic [3:0]       ard_sel;
    logic             ard_is_word;
    logic [31:0]      rd_data, frd_data, ard_data;
    logic [63:0]      qrd_data;
    logic [3:0]       digit_data;
    int               errors, n_compared;
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    exec_datapath dp (.clk_sys(clk_sys), .data_wr(data_wr), .quad_wr(quad_wr),
        .field_wr(field_wr), .addr_wr(addr_wr));
    data_register_file dut (.clk_sys(clk_sys), .rst_n(rst_n), .data_wr(data_wr),
        .quad_wr(quad_wr), .field_wr(field_wr), .addr_wr(addr_wr), .rd_sel(rd_sel),
        .rd_size(rd_size), .qrd_hi_sel(qrd_hi_sel), .qrd_lo_sel(qrd_lo_sel),
        .frd_sel(frd_sel), .frd_offset(frd_offset), .frd_width(frd_width),
        .digit_sel(digit_sel), .digit_idx(digit_idx), .ard_sel(ard_sel),
        .ard_is_word(ard_is_word), .rd_data(rd_data), .qrd_data(qrd_data),
        .frd_data(frd_data), .digit_data(digit_data), .ard_data(ard_data));
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick;
        @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    task automatic point(input logic [2:0] s, input op_size_t z);
        {rd_sel, frd_sel, digit_sel, qrd_lo_sel} = {4{s}};
        rd_size = z;
        tick;
    endtask
    task automatic t_sized;
        for (int i = 0; i < 8; i++)
            dp.put_data(i[2:0], SZ_LONG, 32'h0101_0101 * i);
        for (int i = 0; i < 8; i++)
        begin
            point(i[2:0], SZ_LONG);
            chk("long", 32'h0101_0101 * i, rd_data);
        end
        qrd_lo_sel = 3'd2;
        dp.put_data(2, SZ_BYTE, 32'h1111_1155);
        point(2, SZ_BYTE);
        chk("byte", 64'h55, rd_data);
        chk("byte keep", 64'h0202_0255, qrd_data[31:0]);
        dp.put_data(2, SZ_WORD, 32'h2222_8766);
        point(2, SZ_WORD);
        chk("word", 64'h8766, rd_data);
        chk("word keep", 64'h0202_8766, qrd_data[31:0]);
        $display("test sized done");
    endtask
    task automatic t_field;
        dp.put_data(5, SZ_LONG, 32'h8000_0000);
        frd_offset = 5'd31;
        frd_width = 6'd2;
        point(5, SZ_LONG);
        chk("field wrap", 64'h1, frd_data);
        frd_offset = 5'd0;
        frd_width = 6'd1;
        point(5, SZ_LONG);
        chk("field msb", 64'h1, frd_data);
        dp.put_field(6, 5'd30, 6'd4, 32'ha);
        point(6, SZ_LONG);
        chk("field insert", 64'h8606_0606, rd_data);
        $display("test field done");
    endtask
    task automatic t_quad;
        qrd_hi_sel = 3'd1;
        qrd_lo_sel = 3'd4;
        dp.put_quad(1, 4, 64'h0123_4567_89ab_cdef);
        tick;
        chk("quad", 64'h0123_4567_89ab_cdef, qrd_data);
        {qrd_hi_sel, qrd_lo_sel} = {3'd4, 3'd1};
        tick;
        chk("quad swap", 64'h89ab_cdef_0123_4567, qrd_data);
        dp.put_data(7, SZ_LONG, 32'h0908_0706);
        for (int i = 0; i < 4; i++)
        begin
            digit_idx = i[1:0];
            point(7, SZ_LONG);
            chk("digit", 64'h6 + i, digit_data);
        end
        $display("test quad digit done");
    endtask
    task automatic t_addr;
        dp.put_addr(4'd9, 1'b0, 32'hdead_beef);
        ard_sel = 4'd9;
        tick;
        chk("stack ptr", 64'hdead_beef, ard_data);
        ard_is_word = 1'b1;
        tick;
        chk("addr word", 64'hffff_beef, ard_data);
        dp.put_addr(4'd12, 1'b0, 32'h1);
        ard_sel = 4'd12;
        tick;
        chk("unmapped", 64'h0, ard_data);
        $display("test addr done");
    endtask
    task automatic t_reset;
        ard_sel = 4'd9;
        ard_is_word = 1'b0;
        rst_n = 1'b0;
        tick;
        rst_n = 1'b1;
        point(6, SZ_LONG);
        chk("reset data", 64'h0, rd_data);
        chk("reset addr", 64'h0, ard_data);
        $display("test reset done");
    endtask
    task automatic give_verdict;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        {errors, n_compared, rst_n, ard_is_word} = '0;
        {rd_sel, qrd_hi_sel, qrd_lo_sel, frd_sel, digit_sel} = '0;
        {frd_offset, frd_width, digit_idx, ard_sel} = '0;
        rd_size = SZ_LONG;
        repeat (3) @(negedge clk_sys);
        rst_n = 1'b1;
        point(0, SZ_LONG);
        chk("reset", 64'h0, rd_data);
        t_sized;
        t_field;
        t_quad;
        t_addr;
        t_reset;
        give_verdict;
    end
    initial
    begin
        #20000;
        errors++;
        give_verdict;
    end
endmodule
bind data_register_file regfile_props u_props (.clk_sys(clk_sys), .rst_n(rst_n),
    .data_wr(data_wr), .quad_wr(quad_wr), .field_wr(field_wr), .rd_sel(rd_sel),
    .rd_size(rd_size), .qrd_hi_sel(qrd_hi_sel), .qrd_lo_sel(qrd_lo_sel),
    .frd_sel(frd_sel), .frd_offset(frd_offset), .frd_width(frd_width),
    .ard_sel(ard_sel), .rd_data(rd_data), .qrd_data(qrd_data), .frd_data(frd_data),
    .ard_data(ard_data));
